/* File: verilog/adc_timing_pkg.sv */
// constants for the converter timing and input-select control block
// assumes a 32-bit axi4-lite slave with word-aligned registers
package adc_timing_pkg;
    // register byte offsets
    localparam logic [3:0] ADDR_TIMING = 4'h0;
    localparam logic [3:0] ADDR_INSEL = 4'h4;
    localparam logic [3:0] ADDR_CTRL = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hc;
    // timing register fields
    localparam int CLK_SRC_BIT = 15;
    localparam int SAMP_TIME_LSB = 8;
    localparam int DIV_LSB = 0;
    localparam logic [31:0] TIMING_MASK = 32'h0000_9fff;
    // input select fields
    localparam int NEG_B_BIT = 31;
    localparam int POS_B_LSB = 24;
    localparam int NEG_A_BIT = 23;
    localparam int POS_A_LSB = 16;
    localparam logic [31:0] INSEL_MASK = 32'h8f8f_0000;
    // control register fields
    localparam int ALT_BIT = 0;
    localparam int TRIG_LSB = 1;
    localparam int START_BIT = 4;
    localparam logic [31:0] CTRL_MASK = 32'h0000_000f;
    localparam logic [2:0] TRIG_AUTO = 3'h7;
    // reset values
    localparam logic [31:0] TIMING_RESET = 32'h0000_0000;
    localparam logic [31:0] INSEL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: verilog/adc_timing_ctrl.sv */
// converter timing and input-select control with an axi4-lite register slave
// assumes the rc oscillator tick arrives asynchronously; core answers with a level
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
module adc_timing_ctrl (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // axi4-lite write address and data
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // rc oscillator tick from outside the clock domain
    input wire logic rc_osc_i,
    // converter core
    input wire logic conv_done_i,
    output logic sampling_o,
    output logic conv_start_o,
    output logic conv_clk_en_o,
    output logic [3:0] pos_select_o,
    output logic neg_select_o,
    output logic using_b_o
);
    //------------------------------------------------------------
    // registers and bus state
    //------------------------------------------------------------
    logic [31:0] timing_ff, nxt_timing;
    logic [31:0] insel_ff, nxt_insel;
    logic [31:0] ctrl_ff, nxt_ctrl;
    logic [3:0] awaddr_ff, nxt_awaddr;
    logic aw_have_ff, nxt_aw_have;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic w_have_ff, nxt_w_have;
    logic bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] rresp_ff, nxt_rresp;
    logic start_pulse;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r & mask;
    endfunction

    function automatic logic mapped(input logic [3:0] a);
        return a == adc_timing_pkg::ADDR_TIMING || a == adc_timing_pkg::ADDR_INSEL ||
               a == adc_timing_pkg::ADDR_CTRL || a == adc_timing_pkg::ADDR_STATUS;
    endfunction

    // status word driven by the sequencer below
    logic [31:0] status_word;

    assign s_axi_awready = !aw_have_ff && !bvalid_ff;
    assign s_axi_wready = !w_have_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    always_comb begin
        nxt_timing = timing_ff;
        nxt_insel = insel_ff;
        nxt_ctrl = ctrl_ff;
        nxt_awaddr = awaddr_ff;
        nxt_aw_have = aw_have_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_w_have = w_have_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        start_pulse = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_awaddr = s_axi_awaddr;
            nxt_aw_have = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
            nxt_w_have = 1'b1;
        end
        if (aw_have_ff && w_have_ff) begin
            nxt_aw_have = 1'b0;
            nxt_w_have = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = mapped(awaddr_ff) ? adc_timing_pkg::RESP_OKAY
                                          : adc_timing_pkg::RESP_SLVERR;
            case (awaddr_ff)
                adc_timing_pkg::ADDR_TIMING: begin
                    nxt_timing = merge(timing_ff, wdata_ff, wstrb_ff,
                                       adc_timing_pkg::TIMING_MASK);
                end
                adc_timing_pkg::ADDR_INSEL: begin
                    nxt_insel = merge(insel_ff, wdata_ff, wstrb_ff,
                                      adc_timing_pkg::INSEL_MASK);
                end
                adc_timing_pkg::ADDR_CTRL: begin
                    nxt_ctrl = merge(ctrl_ff, wdata_ff, wstrb_ff, adc_timing_pkg::CTRL_MASK);
                    start_pulse = wstrb_ff[0] && wdata_ff[adc_timing_pkg::START_BIT];
                end
                default: begin
                end
            endcase
        end
        if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = adc_timing_pkg::RESP_OKAY;
            case (s_axi_araddr)
                adc_timing_pkg::ADDR_TIMING: nxt_rdata = timing_ff;
                adc_timing_pkg::ADDR_INSEL: nxt_rdata = insel_ff;
                adc_timing_pkg::ADDR_CTRL: nxt_rdata = ctrl_ff;
                adc_timing_pkg::ADDR_STATUS: nxt_rdata = status_word;
                default: begin
                    nxt_rdata = 32'h0000_0000;
                    nxt_rresp = adc_timing_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            timing_ff <= adc_timing_pkg::TIMING_RESET;
            insel_ff <= adc_timing_pkg::INSEL_RESET;
            ctrl_ff <= adc_timing_pkg::CTRL_RESET;
            awaddr_ff <= 4'h0;
            aw_have_ff <= 1'b0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            w_have_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'h0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= 2'h0;
        end else begin
            timing_ff <= nxt_timing;
            insel_ff <= nxt_insel;
            ctrl_ff <= nxt_ctrl;
            awaddr_ff <= nxt_awaddr;
            aw_have_ff <= nxt_aw_have;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            w_have_ff <= nxt_w_have;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    //------------------------------------------------------------
    // conversion clock enable
    //------------------------------------------------------------
    logic conv_clock_source_sel;
    logic [7:0] conv_clock_divider;
    logic [4:0] auto_sample_time;
    logic [2:0] trigger_source_sel;
    logic alternate_sample_enable;
    logic [2:0] rc_sync_ff, nxt_rc_sync;
    logic [8:0] div_cnt_ff, nxt_div_cnt;
    logic tick;

    assign conv_clock_source_sel = timing_ff[adc_timing_pkg::CLK_SRC_BIT];
    assign conv_clock_divider = timing_ff[adc_timing_pkg::DIV_LSB +: 8];
    assign auto_sample_time = timing_ff[adc_timing_pkg::SAMP_TIME_LSB +: 5];
    assign trigger_source_sel = ctrl_ff[adc_timing_pkg::TRIG_LSB +: 3];
    assign alternate_sample_enable = ctrl_ff[adc_timing_pkg::ALT_BIT];

    always_comb begin
        nxt_rc_sync = {rc_sync_ff[1:0], rc_osc_i};
        nxt_div_cnt = div_cnt_ff + 9'h001;
        tick = 1'b0;
        if (conv_clock_source_sel) begin
            // divider is bypassed; one period per rising rc edge
            tick = rc_sync_ff[1] && !rc_sync_ff[2];
            nxt_div_cnt = 9'h000;
        end else if (div_cnt_ff >= {conv_clock_divider, 1'b1}) begin
            tick = 1'b1;
            nxt_div_cnt = 9'h000;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rc_sync_ff <= 3'h0;
            div_cnt_ff <= 9'h000;
        end else begin
            rc_sync_ff <= nxt_rc_sync;
            div_cnt_ff <= nxt_div_cnt;
        end
    end
    assign conv_clk_en_o = tick;

    //------------------------------------------------------------
    // sample sequencer and input selection
    //------------------------------------------------------------
    typedef enum logic [1:0] {IDLE, SAMPLE, CONVERT} seq_e;
    seq_e state_ff, nxt_state;
    logic [4:0] samp_cnt_ff, nxt_samp_cnt;
    logic use_b_ff, nxt_use_b;
    logic [1:0] done_sync_ff, nxt_done_sync;
    logic start_ff, nxt_start;

    assign status_word = {28'h0000000, use_b_ff, state_ff == CONVERT, state_ff == SAMPLE,
                          state_ff != IDLE};

    always_comb begin
        nxt_state = state_ff;
        nxt_samp_cnt = samp_cnt_ff;
        nxt_use_b = use_b_ff;
        nxt_done_sync = {done_sync_ff[0], conv_done_i};
        nxt_start = 1'b0;
        if (!alternate_sample_enable) begin
            nxt_use_b = 1'b0;
        end
        case (state_ff)
            IDLE: begin
                nxt_use_b = 1'b0;
                if (start_pulse) begin
                    nxt_state = SAMPLE;
                    nxt_samp_cnt = 5'h00;
                end
            end
            SAMPLE: begin
                if (trigger_source_sel == adc_timing_pkg::TRIG_AUTO) begin
                    if (tick) begin
                        nxt_samp_cnt = samp_cnt_ff + 5'h01;
                    end
                    if (tick && samp_cnt_ff + 5'h01 >= auto_sample_time) begin
                        nxt_state = CONVERT;
                        nxt_start = 1'b1;
                    end
                end else if (start_pulse) begin
                    nxt_state = CONVERT;
                    nxt_start = 1'b1;
                end
            end
            CONVERT: begin
                if (done_sync_ff[1]) begin
                    nxt_state = SAMPLE;
                    nxt_samp_cnt = 5'h00;
                    nxt_use_b = alternate_sample_enable && !use_b_ff;
                end
            end
            default: nxt_state = IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_ff <= IDLE;
            samp_cnt_ff <= 5'h00;
            use_b_ff <= 1'b0;
            done_sync_ff <= 2'h0;
            start_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            samp_cnt_ff <= nxt_samp_cnt;
            use_b_ff <= nxt_use_b;
            done_sync_ff <= nxt_done_sync;
            start_ff <= nxt_start;
        end
    end

    assign sampling_o = state_ff == SAMPLE;
    assign conv_start_o = start_ff;
    assign using_b_o = use_b_ff;
    // mux codes pass straight to the analog core
    assign pos_select_o = use_b_ff ? insel_ff[adc_timing_pkg::POS_B_LSB +: 4]
                                   : insel_ff[adc_timing_pkg::POS_A_LSB +: 4];
    assign neg_select_o = use_b_ff ? insel_ff[adc_timing_pkg::NEG_B_BIT]
                                   : insel_ff[adc_timing_pkg::NEG_A_BIT];
endmodule

/* File: verif/adc_core_model.sv */
// behavioural converter core answering each conversion start
// assumes the block returns to sampling once done is seen
`timescale 1ns/100ps
module adc_core_model (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic conv_start_i,
    input wire logic sampling_i,
    input wire logic slow_i,
    output logic conv_done_o
);
    int left;
    // done stays high until the block is sampling again
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            left <= 0;
            conv_done_o <= 1'h0;
        end else if (conv_start_i) begin
            left <= slow_i ? 40 : 3;
        end else if (left > 1) begin
            left <= left - 1;
        end else if (left == 1) begin
            left <= 0;
            conv_done_o <= 1'h1;
        end else if (sampling_i) begin
            conv_done_o <= 1'h0;
        end
    end
endmodule

/* File: verif/adc_timing_ctrl_properties.sv */
// port checker for the timing and input-select control block
// assumes it is bound onto the design top, one clock domain
`timescale 1ns/100ps
module adc_timing_ctrl_properties (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sampling_o,
    input wire logic conv_start_o,
    input wire logic conv_clk_en_o,
    input wire logic using_b_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_new_sample;
        sampling_o && !$past(sampling_o);
    endsequence
    property p_start_pulse;
        conv_start_o |=> !conv_start_o;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start too long");
    property p_start_cause;
        conv_start_o |-> $past(sampling_o);
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("start without sample");
    property p_tick_gap;
        conv_clk_en_o |=> !conv_clk_en_o;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
    property p_side_flip;
        $changed(using_b_o) |-> s_new_sample;
    endproperty
    a_side_flip: assert property (p_side_flip) else $error("side changed mid sample");
    property p_wr_answer;
        s_wr_take |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
    property p_ar_refuse;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_refuse: assert property (p_ar_refuse) else $error("read taken while busy");
endmodule

/* File: verif/adc_sample_timing_and_input_select_bench.sv */
// self-checking bench for the timing and input-select control block
// assumes the core model and the port checker sit beside the design
`timescale 1ns/100ps
module adc_sample_timing_and_input_select_bench;
    logic clk_i = 1'h0;
    logic resetn_i = 1'h0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, rc_osc_i = 1'h0, slow = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v, rd_v;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic conv_done_i, sampling_o, conv_start_o, conv_clk_en_o, neg_select_o, using_b_o;
    logic [3:0] pos_select_o;
    int err_count = 0, n_tests = 0, cnt = 0, last = 0, nst = 0, g, d, s, i;
    adc_timing_ctrl dut (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .rc_osc_i(rc_osc_i),
        .conv_done_i(conv_done_i),
        .sampling_o(sampling_o),
        .conv_start_o(conv_start_o),
        .conv_clk_en_o(conv_clk_en_o),
        .pos_select_o(pos_select_o),
        .neg_select_o(neg_select_o),
        .using_b_o(using_b_o)
    );
    adc_core_model core (.clk_i(clk_i), .resetn_i(resetn_i), .conv_start_i(conv_start_o),
        .sampling_i(sampling_o), .slow_i(slow), .conv_done_o(conv_done_i));
    initial forever #10 clk_i = ~clk_i;
    always begin
        repeat (5) @(posedge clk_i);
        rc_osc_i <= ~rc_osc_i;
    end
    // ticks seen per sample, and count of conversion starts
    always @(negedge clk_i) begin
        if (conv_start_o) begin
            last = cnt;
            cnt = 0;
            nst++;
        end else if (conv_clk_en_o && sampling_o) cnt++;
    end
    task automatic end_sim;
        if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] o);
        n_tests++;
        if (o !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, o);
        end
    endtask
    task automatic tmo;
        chk("wait bound", 32'h1, 32'h0);
        end_sim;
    endtask
    task automatic rst;
        resetn_i <= 1'h0;
        repeat (20) @(posedge clk_i);
        cnt = 0;
        nst = 0;
        resetn_i <= 1'h1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] dt);
        logic ha, hw, hb;
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= dt;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (int k = 0; k < 100; k++) begin
            @(negedge clk_i);
            ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            hb = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge clk_i);
            if (ha) s_axi_awvalid <= 1'h0;
            if (hw) s_axi_wvalid <= 1'h0;
            if (hb) begin
                s_axi_bready <= 1'h0;
                return;
            end
        end
        tmo;
    endtask
    task automatic rd(input logic [3:0] a);
        logic ha, hr;
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (int k = 0; k < 100; k++) begin
            @(negedge clk_i);
            ha = s_axi_arvalid && s_axi_arready;
            hr = s_axi_rvalid;
            rd_v = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge clk_i);
            if (ha) s_axi_arvalid <= 1'h0;
            if (hr) begin
                s_axi_rready <= 1'h0;
                return;
            end
        end
        tmo;
    endtask
    task automatic wait_start(input int tgt);
        for (int k = 0; k < 5000; k++) begin
            @(negedge clk_i);
            if (nst >= tgt) return;
        end
        tmo;
    endtask
    task automatic gap;
        g = 0;
        for (int k = 0; k < 3000; k++) begin
            @(negedge clk_i);
            if (conv_clk_en_o && g > 0) return;
            if (conv_clk_en_o || g > 0) g++;
        end
        tmo;
    endtask
    initial begin
        void'($urandom(34));
        rst;
        for (i = 0; i < 4; i++) begin
            rd(4'(i * 4));
            chk("reset value", 32'h0, rd_v);
        end
        for (i = 0; i < 4; i++) begin
            v = $urandom;
            if (v[12:8] == 5'h00) v[8] = 1'b1;
            wr(adc_timing_pkg::ADDR_TIMING, v);
            chk("write resp", 32'h0, 32'(rsp));
            rd(adc_timing_pkg::ADDR_TIMING);
            chk("timing", v & 32'h0000_9fff, rd_v);
            wr(adc_timing_pkg::ADDR_INSEL, v);
            rd(adc_timing_pkg::ADDR_INSEL);
            chk("insel", v & 32'h8f8f_0000, rd_v);
        end
        rd(4'h6);
        chk("unmapped resp", 32'h2, 32'(rsp));
        chk("unmapped data", 32'h0, rd_v);
        wr(4'h6, 32'hffff_ffff);
        chk("unmapped wr resp", 32'h2, 32'(rsp));
        rd(adc_timing_pkg::ADDR_INSEL);
        chk("unmapped wr ignored", v & 32'h8f8f_0000, rd_v);
        for (i = 0; i < 16; i++) begin
            v = ($urandom & 32'h8f00_0000) | (32'(i) << 16) | (32'(i & 1) << 23);
            wr(adc_timing_pkg::ADDR_INSEL, v);
            @(negedge clk_i);
            chk("pos a", 32'(i), 32'(pos_select_o));
            chk("neg a", 32'(i & 1), 32'(neg_select_o));
        end
        wr(adc_timing_pkg::ADDR_INSEL, 32'h0983_0000);
        wr(adc_timing_pkg::ADDR_TIMING, 32'h0000_1f00);
        wr(adc_timing_pkg::ADDR_CTRL, 32'h0000_0010);
        repeat (100) @(negedge clk_i);
        chk("manual early start", 32'h0, 32'(nst));
        rd(adc_timing_pkg::ADDR_STATUS);
        chk("status sampling", 32'h3, rd_v);
        for (i = 0; i < 2; i++) begin
            wr(adc_timing_pkg::ADDR_CTRL, 32'h0000_0010);
            wait_start(i + 1);
            chk("manual side", 32'h0, 32'(using_b_o));
            chk("manual pos", 32'h3, 32'(pos_select_o));
            chk("manual neg", 32'h1, 32'(neg_select_o));
            repeat (60) @(posedge clk_i);
        end
        rst;
        d = $urandom_range(3, 1);
        s = $urandom_range(6, 3);
        wr(adc_timing_pkg::ADDR_TIMING, 32'((s << 8) | d));
        wr(adc_timing_pkg::ADDR_INSEL, 32'h0983_0000);
        wr(adc_timing_pkg::ADDR_CTRL, 32'h0000_001f);
        gap;
        chk("bus tick period", 32'(2 * (d + 1)), 32'(g));
        for (i = 0; i < 4; i++) begin
            slow <= i[1];
            wait_start(i + 1);
            chk("auto length", 32'(s), 32'(last));
            chk("alt side", 32'(i & 1), 32'(using_b_o));
            chk("alt pos", (i & 1) ? 32'h9 : 32'h3, 32'(pos_select_o));
        end
        rst;
        wr(adc_timing_pkg::ADDR_TIMING, 32'h0000_83ff);
        wr(adc_timing_pkg::ADDR_CTRL, 32'h0000_001e);
        gap;
        chk("rc tick period", 32'ha, 32'(g));
        for (i = 0; i < 2; i++) begin
            wait_start(i + 1);
            chk("rc auto length", 32'h3, 32'(last));
            chk("single side", 32'h0, 32'(using_b_o));
        end
        end_sim;
    end
endmodule
bind adc_timing_ctrl adc_timing_ctrl_properties props (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .sampling_o(sampling_o),
    .conv_start_o(conv_start_o),
    .conv_clk_en_o(conv_clk_en_o),
    .using_b_o(using_b_o)
);
